// *** itf_checker.sv ***
// Purpose: port checks for itf_top
// Assumes: terminals quiet through reset
// Notes:   edge checks allow slack in sync depth
`timescale 1ns/1ps
`default_nettype none
module itf_checker #(
    parameter NIN  = 20,
    parameter NINT = 8
) (
    // Clock and reset
    input wire logic            CLOCK,
    input wire logic            RESET,
    // Bus and terminals
    input wire logic            PSEL,
    input wire logic            PENABLE,
    input wire logic            PREADY,
    input wire logic            PSLVERR,
    input wire logic [NIN-1:0]  TERMINAL_IN,
    input wire logic [NINT-1:0] QUICK_OUT,
    input wire logic [NINT-1:0] INTR_PULSE
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RESET);
    property p_rdy_one; PREADY |=> !PREADY; endproperty
    a_rdy_one: assert property (p_rdy_one) else $error("ready held");
    property p_rdy_lat; PSEL && PENABLE && !PREADY |=> PREADY; endproperty
    a_rdy_lat: assert property (p_rdy_lat) else $error("ready late");
    property p_rdy_sel; PREADY |-> PSEL && PENABLE; endproperty
    a_rdy_sel: assert property (p_rdy_sel) else $error("stray ready");
    property p_err; PSLVERR |-> PREADY; endproperty
    a_err: assert property (p_err) else $error("stray error");
    property p_int_one; (INTR_PULSE & $past(INTR_PULSE)) == '0; endproperty
    a_int_one: assert property (p_int_one) else $error("long pulse");
    // No pulse without a pin change three to six edges back
    property p_int_edge;
        INTR_PULSE[0] |-> $past(TERMINAL_IN[0], 3) != $past(TERMINAL_IN[0], 6);
    endproperty
    a_int_edge: assert property (p_int_edge) else $error("no edge");
    property p_excl; (QUICK_OUT & INTR_PULSE) == '0; endproperty
    a_excl: assert property (p_excl) else $error("two functions");
    property p_quick;
        $rose(QUICK_OUT[1]) |-> $past(TERMINAL_IN[1], 2);
    endproperty
    a_quick: assert property (p_quick) else $error("quick early");
endmodule
bind itf_top itf_checker #(.NIN(NIN), .NINT(NINT)) u_chk (
    .CLOCK(CLOCK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .TERMINAL_IN(TERMINAL_IN),
    .QUICK_OUT(QUICK_OUT), .INTR_PULSE(INTR_PULSE));
`default_nettype wire

// *** itf_defines.vh ***
// Purpose: constants for the input terminal function block
// Assumes: 25 MHz clock, 32-bit APB data, byte addresses
// Notes:   times in microseconds, cycle counts derived from them
`ifndef ITF_DEFINES_VH
`define ITF_DEFINES_VH
`define ITF_CLK_MHZ        25
`define ITF_FILT_US_0P5    500
`define ITF_FILT_US_1      1000
`define ITF_FILT_US_2      2000
`define ITF_FILT_US_4      4000
`define ITF_FILT_US_8      8000
`define ITF_FILT_US_16     16000
`define ITF_FILT_US_32     32000
`define ITF_FILT_CODE_NONE 4'h0
`define ITF_FILT_CODE_DEF  4'h5
`define ITF_FILT_CODE_MAX  4'h7
`define ITF_FUNC_PLAIN     2'h0
`define ITF_FUNC_QUICK     2'h1
`define ITF_FUNC_INTR      2'h2
`define ITF_SRC_NONE       4'h0
`define ITF_SRC_PULSE0     4'h1
`define ITF_SRC_PULSE3     4'h4
`define ITF_SRC_CNT0       4'h5
`define ITF_SRC_CNT3       4'h8
`define ITF_OFF_FILT       12'h000
`define ITF_OFF_FUNC       12'h004
`define ITF_OFF_EDGE       12'h008
`define ITF_OFF_CTRL       12'h00c
`define ITF_OFF_INPUT      12'h010
`define ITF_OFF_EVENT      12'h014
`define ITF_OFF_ACTIVE     12'h018
`define ITF_OFF_SRCSEL     12'h020
`define ITF_OFF_LATCH      12'h040
`define ITF_OFF_SEL_SPAN   12'h020
`define ITF_OFF_LATCH_SPAN 12'h020
`endif

// *** itf_filter.v ***
// Purpose: debounce of one input terminal
// Assumes: input already synchronised to CLOCK
// Notes:   bypass passes the synchronised level straight through
`timescale 1ns/1ps
`default_nettype none
module itf_filter #(
    parameter CW = 20
) (
    input  wire          clk,
    input  wire          rst,
    input  wire          din,
    input  wire          bypass,
    input  wire [CW-1:0] limit,
    output reg           dout_q
);
    reg [CW-1:0] cnt_q;

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q  <= {CW{1'b0}};
            dout_q <= 1'b0;
        end else if (bypass || din == dout_q) begin
            cnt_q  <= {CW{1'b0}};
            if (bypass) begin
                dout_q <= din;
            end
        end else if (cnt_q >= limit) begin
            // Level held for the full time constant
            cnt_q  <= {CW{1'b0}};
            dout_q <= din;
        end else begin
            cnt_q <= cnt_q + {{(CW-1){1'b0}}, 1'b1};
        end
    end
endmodule
`default_nettype wire

// *** itf_sensor.sv ***
// Purpose: field switches on the terminals
// Assumes: wanted levels change at a clock edge
// Notes:   contacts chatter before settling
`timescale 1ns/1ps
`default_nettype none
module itf_sensor (
    // Clock
    input wire logic        clk,
    // Wanted levels and chatter length
    input wire logic [19:0] want,
    input wire logic [3:0]  bounce,
    // Terminal pins
    output var logic [19:0] pin
);
    logic [19:0] last_q = '0;
    logic [3:0]  cnt_q [20] = '{default: '0};
    initial pin = '0;
    always @(posedge clk) begin
        last_q <= want;
        for (int i = 0; i < 20; i++) begin
            if (want[i] != last_q[i] && bounce != 0) begin
                cnt_q[i] <= bounce;
                pin[i]   <= ~pin[i];
            end else if (cnt_q[i] != 0) begin
                cnt_q[i] <= cnt_q[i] - 1;
                pin[i]   <= ~pin[i];
            end else
                pin[i] <= want[i];
        end
    end
endmodule
`default_nettype wire

// *** itf_top.v ***
// Purpose: input terminal function configuration with APB registers
// Assumes: terminals asynchronous to CLOCK; values come from same domain
// Notes:   power-up settings are captured after a restart pulse
//
// The register offsets and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "itf_defines.vh"
module itf_top #(
    parameter NIN  = 20,
    parameter NINT = 8,
    parameter CW   = 20
) (
    // Clock and reset
    input  wire              CLOCK,
    input  wire              RESET,
    // APB slave
    input  wire              PSEL,
    input  wire              PENABLE,
    input  wire              PWRITE,
    input  wire [11:0]       PADDR,
    input  wire [31:0]       PWDATA,
    output reg               PREADY,
    output reg  [31:0]       PRDATA,
    output reg               PSLVERR,
    // Field terminals
    input  wire [NIN-1:0]    TERMINAL_IN,
    // Values that may be latched
    input  wire [127:0]      PULSE_POS,
    input  wire [127:0]      COUNTER_PV,
    // Terminal results
    output reg  [NIN-1:0]    PLAIN_OUT,
    output reg  [NINT-1:0]   QUICK_OUT,
    output reg  [NINT-1:0]   INTR_PULSE
);
    // Staged settings (software) and active settings (hardware)
    reg [3:0]        filt_stage_q, filt_q;
    reg [2*NINT-1:0] func_stage_q, func_q;
    reg [NINT-1:0]   edge_stage_q, edge_q;
    reg [4*NINT-1:0] src_stage_q, src_q;
    reg [NIN-1:0]    s1_q, s2_q, prev_q;
    reg [31:0]       latch_q [0:NINT-1];
    reg [NINT-1:0]   event_q;
    reg [CW-1:0]     limit;
    reg [NIN-1:0]    bypass;
    reg [NINT-1:0]   fire;
    wire [NIN-1:0]   filt_out;
    wire             wr = PSEL & PENABLE & PWRITE & ~PREADY;
    wire             rd = PSEL & PENABLE & ~PWRITE & ~PREADY;
    integer          i;
    integer          j;
    integer          k;

    function [CW-1:0] us_to_cyc;
        input [31:0] us;
        reg   [31:0] prod;
        begin
            // Longest time constant must still fit in CW bits
            prod      = us * `ITF_CLK_MHZ;
            us_to_cyc = prod[CW-1:0];
        end
    endfunction

    function [31:0] pick;
        input [3:0]   sel;
        input [127:0] pos;
        input [127:0] pv;
        begin
            if (sel >= `ITF_SRC_PULSE0 && sel <= `ITF_SRC_PULSE3)
                pick = pos[(sel - `ITF_SRC_PULSE0)*32 +: 32];
            else if (sel >= `ITF_SRC_CNT0 && sel <= `ITF_SRC_CNT3)
                pick = pv[(sel - `ITF_SRC_CNT0)*32 +: 32];
            else
                pick = 32'h0000_0000;
        end
    endfunction

    always @* begin
        case (filt_q)
            4'h1:    limit = us_to_cyc(`ITF_FILT_US_0P5);
            4'h2:    limit = us_to_cyc(`ITF_FILT_US_1);
            4'h3:    limit = us_to_cyc(`ITF_FILT_US_2);
            4'h4:    limit = us_to_cyc(`ITF_FILT_US_4);
            4'h5:    limit = us_to_cyc(`ITF_FILT_US_8);
            4'h6:    limit = us_to_cyc(`ITF_FILT_US_16);
            4'h7:    limit = us_to_cyc(`ITF_FILT_US_32);
            default: limit = {CW{1'b0}};
        endcase
        bypass = {NIN{filt_q == `ITF_FILT_CODE_NONE}};
        fire   = {NINT{1'b0}};
        for (i = 0; i < NINT; i = i + 1) begin
            // One function per terminal, decoded from one field
            if (func_q[2*i +: 2] != `ITF_FUNC_PLAIN)
                bypass[i] = 1'b1;
            fire[i] = func_q[2*i +: 2] == `ITF_FUNC_INTR &&
                      (edge_q[i] ? (prev_q[i] & ~s2_q[i])
                                 : (~prev_q[i] & s2_q[i]));
        end
    end

    genvar g;
    generate
        for (g = 0; g < NIN; g = g + 1) begin : gen_filt
            itf_filter #(.CW(CW)) u_filt (
                .clk    (CLOCK),
                .rst    (RESET),
                .din    (s2_q[g]),
                .bypass (bypass[g]),
                .limit  (limit),
                .dout_q (filt_out[g])
            );
        end
    endgenerate

    always @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            s1_q         <= {NIN{1'b0}};
            s2_q         <= {NIN{1'b0}};
            prev_q       <= {NIN{1'b0}};
            filt_stage_q <= `ITF_FILT_CODE_DEF;
            filt_q       <= `ITF_FILT_CODE_DEF;
            func_stage_q <= {NINT{`ITF_FUNC_PLAIN}};
            func_q       <= {NINT{`ITF_FUNC_PLAIN}};
            edge_stage_q <= {NINT{1'b0}};
            edge_q       <= {NINT{1'b0}};
            src_stage_q  <= {NINT{`ITF_SRC_NONE}};
            src_q        <= {NINT{`ITF_SRC_NONE}};
            event_q      <= {NINT{1'b0}};
            PLAIN_OUT    <= {NIN{1'b0}};
            QUICK_OUT    <= {NINT{1'b0}};
            INTR_PULSE   <= {NINT{1'b0}};
            PREADY       <= 1'b0;
            PRDATA       <= 32'h0000_0000;
            PSLVERR      <= 1'b0;
        end else begin
            // Only s2_q of the synchroniser feeds logic
            s1_q   <= TERMINAL_IN;
            s2_q   <= s1_q;
            prev_q <= s2_q;
            PLAIN_OUT  <= filt_out;
            INTR_PULSE <= fire;
            for (k = 0; k < NINT; k = k + 1) begin
                // Unfiltered, so a quick input sees every change
                QUICK_OUT[k] <= func_q[2*k +: 2] == `ITF_FUNC_QUICK &&
                                s2_q[k];
            end
            // Sticky events; a new edge wins over the clear
            event_q <= fire | (event_q &
                       ~((wr && PADDR == `ITF_OFF_EVENT) ?
                         PWDATA[NINT-1:0] : {NINT{1'b0}}));
            // One wait state: ready answers the first access cycle
            PREADY  <= PSEL & PENABLE & ~PREADY;
            PSLVERR <= 1'b0;
            if (wr) begin
                case (PADDR)
                    `ITF_OFF_FILT:
                        if (PWDATA[3:0] <= `ITF_FILT_CODE_MAX)
                            filt_stage_q <= PWDATA[3:0];
                    `ITF_OFF_FUNC: func_stage_q <= PWDATA[2*NINT-1:0];
                    `ITF_OFF_EDGE: edge_stage_q <= PWDATA[NINT-1:0];
                    `ITF_OFF_SRCSEL: src_stage_q <= PWDATA[4*NINT-1:0];
                    `ITF_OFF_CTRL: begin
                        // Bit0 power-up restart, bit1 operation start
                        if (PWDATA[0]) begin
                            filt_q <= filt_stage_q;
                            func_q <= func_stage_q;
                            src_q  <= src_stage_q;
                            edge_q <= edge_stage_q;
                        end
                        if (PWDATA[1])
                            edge_q <= edge_stage_q;
                    end
                    `ITF_OFF_EVENT: ;
                    default: PSLVERR <= 1'b1;
                endcase
            end
            if (rd) begin
                PRDATA <= 32'h0000_0000;
                if (PADDR >= `ITF_OFF_LATCH &&
                    PADDR < `ITF_OFF_LATCH + `ITF_OFF_LATCH_SPAN)
                    PRDATA <= latch_q[PADDR[4:2]];
                else begin
                    case (PADDR)
                        `ITF_OFF_FILT:   PRDATA[3:0] <= filt_stage_q;
                        `ITF_OFF_FUNC:   PRDATA[2*NINT-1:0] <= func_stage_q;
                        `ITF_OFF_EDGE:   PRDATA[NINT-1:0] <= edge_stage_q;
                        `ITF_OFF_SRCSEL: PRDATA[4*NINT-1:0] <= src_stage_q;
                        `ITF_OFF_CTRL:   PRDATA <= 32'h0000_0000;
                        `ITF_OFF_INPUT:  PRDATA[NIN-1:0] <= s2_q;
                        `ITF_OFF_EVENT:  PRDATA[NINT-1:0] <= event_q;
                        `ITF_OFF_ACTIVE: PRDATA[2*NINT+3:0] <=
                                         {filt_q, func_q};
                        default:         PSLVERR <= 1'b1;
                    endcase
                end
            end
        end
    end

    // Latch words in a process of their own, one loop variable each
    always @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            for (j = 0; j < NINT; j = j + 1)
                latch_q[j] <= 32'h0000_0000;
        end else begin
            for (j = 0; j < NINT; j = j + 1) begin
                if (fire[j]) begin
                    // Same edge that raises the interrupt
                    latch_q[j] <= pick(src_q[4*j +: 4], PULSE_POS,
                                       COUNTER_PV);
                end
            end
        end
    end
endmodule
`default_nettype wire

// *** tb_input_terminal_function_config.sv ***
// Purpose: self-checking bench for itf_top
// Assumes: one wait state on the bus
// Notes:   filter run with the 0.5 ms code
`timescale 1ns/1ps
`default_nettype none
module tb_input_terminal_function_config;
    logic clock, reset, psel, penable, pwrite, pready, pslverr, er;
    logic [11:0]  paddr;
    logic [31:0]  pwdata, prdata, rd, exp_v;
    logic [19:0]  want, pins, plain_o;
    logic [7:0]   quick_o, intr_o;
    logic [3:0]   bounce;
    logic [127:0] pos = {32'h4444_0404, 32'h3333_0303,
                         32'h2222_0202, 32'h1111_0101};
    logic [127:0] cnt = {32'h8888_0808, 32'h7777_0707,
                         32'h6666_0606, 32'h5555_0505};
    int miscompares, compares, hits;
    itf_top dut (.CLOCK(clock), .RESET(reset), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready),
        .PRDATA(prdata), .PSLVERR(pslverr), .TERMINAL_IN(pins), .PULSE_POS(pos),
        .COUNTER_PV(cnt), .PLAIN_OUT(plain_o), .QUICK_OUT(quick_o),
        .INTR_PULSE(intr_o));
    itf_sensor field (.clk(clock), .want(want), .bounce(bounce), .pin(pins));
    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clock);
        penable <= 1;
        // No limit here: the watchdog ends a hung transfer
        do @(posedge clock); while (pready !== 1'b1);
        rd = prdata; er = pslverr;
        psel <= 0; penable <= 0;
    endtask
    task hit(input int b);
        hits = 0;
        repeat (12) begin @(negedge clock); if (intr_o[b] === 1'b1) hits++; end
        @(posedge clock);
    endtask
    task t_regs;
        apb(0, 12'h000, 0); chk(rd, 32'h5);
        apb(0, 12'h004, 0); chk(rd, 0);
        apb(0, 12'h008, 0); chk(rd, 0);
        apb(0, 12'h020, 0); chk(rd, 0);
        apb(1, 12'h000, 32'h8); apb(0, 12'h000, 0); chk(rd, 32'h5);
        apb(0, 12'h0fc, 0); chk(er, 1);
        $display("t_regs done");
    endtask
    task t_filter;
        apb(1, 12'h000, 32'h1); apb(1, 12'h00c, 32'h1);
        bounce <= 4'h8; want[15] <= 1;
        repeat (12000) @(posedge clock); chk(plain_o[15], 0);
        repeat (1000) @(posedge clock); chk(plain_o[15], 1);
        bounce <= 0;
        $display("t_filter done");
    endtask
    task t_intr;
        apb(1, 12'h004, 32'h26); apb(1, 12'h008, 32'h4);
        apb(1, 12'h020, 32'h802); apb(1, 12'h00c, 32'h1);
        want[0] <= 1; want[1] <= 1; hit(0); chk(hits, 1);
        chk(quick_o[1], 1); chk(plain_o[1], 1);
        exp_v = pos[63:32];
        pos[63:32] <= 32'h0bad_0bad;
        apb(0, 12'h040, 0); chk(rd, exp_v);
        want[2] <= 1; hit(2); chk(hits, 0);
        want[2] <= 0; hit(2); chk(hits, 1);
        apb(0, 12'h048, 0); chk(rd, cnt[127:96]);
        $display("t_intr done");
    endtask
    task t_edge;
        apb(1, 12'h008, 32'h5); apb(1, 12'h00c, 32'h2);
        want[0] <= 0; hit(0); chk(hits, 1);
        want[0] <= 1; hit(0); chk(hits, 0);
        want[3] <= 1; hit(3); chk(hits, 0);
        $display("t_edge done");
    endtask
    task t_status;
        apb(0, 12'h014, 0); chk(rd, 32'h5);
        apb(1, 12'h014, 32'h1); apb(0, 12'h014, 0); chk(rd, 32'h4);
        apb(1, 12'h004, 32'h0); apb(0, 12'h018, 0); chk(rd, 32'h1_0026);
        apb(0, 12'h010, 0); chk(rd, {12'h000, want});
        $display("t_status done");
    endtask
    task t_nofilt;
        apb(1, 12'h000, 32'h0); apb(1, 12'h00c, 32'h1);
        want[16] <= 1;
        repeat (8) @(posedge clock); chk(plain_o[16], 1);
        $display("t_nofilt done");
    endtask
    task summarize;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        clock = 0;
        forever #20 clock = ~clock;
    end
    initial begin
        repeat (40000) @(posedge clock);
        miscompares++;
        summarize;
    end
    initial begin
        reset = 1; psel = 0; penable = 0; pwrite = 0;
        paddr = '0; pwdata = '0; want = '0; bounce = '0;
        repeat (16) @(posedge clock);
        reset <= 0;
        t_regs;
        t_filter;
        t_intr;
        t_status;
        t_edge;
        t_nofilt;
        summarize;
    end
endmodule
`default_nettype wire
